// [hdl/flash_option_trim_config.sv]
// Chosen here: the strobed register port.
`timescale 1ns/1ns
// Operation
// - Timing high and low bytes join into one 16-bit value for flash timing.
// - User options fetched from program memory at reset and applied.
// - User options live at program memory bytes 0000h and 0001h.
// - Erasing page 0 also erases the user option bytes.
// - New option bytes take effect only after the next reset.
// - Factory trim stays in the information page, untouched by erase.
// - Working trim values written by software are lost at reset.
// - Thirty-two trim locations; software writes index 00h..1Fh first.
// - Trim data write replaces working value; read returns it.
// - Option bit 7 picks watchdog interrupt (0) or reset (1).
// - Option bit 6 zero starts watchdog automatically; one waits for arm instruction.
// - Bits 5:4 set oscillator drive; 00 reserved, 01 low, 11 high.
// - Bit 3 one keeps brownout on always; zero disables it in STOP.
// - Bit 2 zero blocks external reads of user code.
// - Bit 0 zero blocks user program, page erase and mass erase.
// - Working trims reload from information area after reset and STOP recovery.
module flash_option_trim_config #(
  parameter int TRIM_DEPTH = option_cfg_pkg::TRIM_COUNT
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  // Register port
  input  wire logic [11:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [7:0]       o_rdata,
  // Flash read port (program memory and information area)
  output logic [15:0]      o_flash_addr,
  output logic             o_flash_info_sel,
  output logic             o_flash_rd,
  input  wire logic [7:0]  i_flash_rdata,
  // Stop mode recovery request
  input  wire logic        i_stop_recover,
  // CPU release
  output logic             o_cpu_release,
  // Flash timing
  output logic [15:0]      o_flash_timing_value,
  // Decoded options
  output logic             o_wdt_reset_on_timeout,
  output logic             o_wdt_auto_on,
  output logic [1:0]       o_osc_drive,
  output logic             o_osc_drive_reserved,
  output logic             o_brownout_always_on,
  output logic             o_read_protect,
  output logic             o_flash_write_lock,
  output logic [7:0]       o_option_one
);
  import option_cfg_pkg::*;

  // ============================================================
  // State
  typedef struct packed {
    load_state_t state;
    logic        rd_pend;
    logic [4:0]  trim_ptr;
    logic [7:0]  opt0;
    logic [7:0]  opt1;
    logic [7:0]  tim_hi;
    logic [7:0]  tim_lo;
    logic [7:0]  trim_idx;
    logic [7:0]  rdata;
  } state_t;

  state_t s_reg;
  state_t s_next;

  logic       trim_we;
  logic [4:0] trim_waddr;
  logic [7:0] trim_wdata;
  logic [7:0] trim_rdata;
  logic       loading;

  assign loading = (s_reg.state != LD_DONE);

  // ============================================================
  // Trim working store
  trim_store #(
    .DEPTH (TRIM_DEPTH)
  ) u_trim (
    .i_clk   (i_clk),
    .i_arst_n(i_arst_n),
    .i_we    (trim_we),
    .i_waddr (trim_waddr),
    .i_wdata (trim_wdata),
    .i_raddr (s_reg.trim_idx[4:0]),
    .o_rdata (trim_rdata)
  );

  // ============================================================
  // Option decode
  option_decode u_dec (
    .i_option              (s_reg.opt0),
    .o_wdt_reset_on_timeout(o_wdt_reset_on_timeout),
    .o_wdt_auto_on         (o_wdt_auto_on),
    .o_osc_drive           (o_osc_drive),
    .o_osc_drive_reserved  (o_osc_drive_reserved),
    .o_brownout_always_on  (o_brownout_always_on),
    .o_read_protect        (o_read_protect),
    .o_flash_write_lock    (o_flash_write_lock)
  );

  // ============================================================
  // Next state
  always_comb begin
    s_next       = s_reg;
    trim_we      = 1'b0;
    trim_waddr   = s_reg.trim_idx[4:0];
    trim_wdata   = i_wdata;
    o_flash_addr = OPTION_ADDR_ZERO;
    o_flash_info_sel = 1'b0;
    o_flash_rd   = 1'b0;

    // Loader: one-cycle flash read latency; rd_pend marks data due
    case (s_reg.state)
      LD_OPT0: begin
        // Plain page 0 flash location: an erased page reads back as FFh here
        o_flash_addr = OPTION_ADDR_ZERO;
        o_flash_rd   = ~s_reg.rd_pend;
        s_next.rd_pend = ~s_reg.rd_pend;
        if (s_reg.rd_pend) begin
          s_next.opt0  = i_flash_rdata;
          s_next.state = LD_OPT1;
        end
      end
      LD_OPT1: begin
        o_flash_addr = OPTION_ADDR_ONE;
        o_flash_rd   = ~s_reg.rd_pend;
        s_next.rd_pend = ~s_reg.rd_pend;
        if (s_reg.rd_pend) begin
          s_next.opt1  = i_flash_rdata;
          s_next.state = LD_TRIM;
        end
      end
      LD_TRIM: begin
        // Information area is read only; nothing here ever writes flash
        o_flash_info_sel = 1'b1;
        o_flash_addr = {11'h000, s_reg.trim_ptr};
        o_flash_rd   = ~s_reg.rd_pend;
        s_next.rd_pend = ~s_reg.rd_pend;
        if (s_reg.rd_pend) begin
          trim_we    = 1'b1;
          trim_waddr = s_reg.trim_ptr;
          trim_wdata = i_flash_rdata;
          s_next.trim_ptr = s_reg.trim_ptr + 5'h01;
          if (s_reg.trim_ptr == 5'(TRIM_DEPTH - 1)) begin
            s_next.state = LD_DONE;
          end
        end
      end
      LD_DONE: begin
        // STOP recovery reloads trims only; option bytes hold until reset
        if (i_stop_recover) begin
          s_next.state    = LD_TRIM;
          s_next.trim_ptr = 5'h00;
          s_next.rd_pend  = 1'b0;
        end
      end
      default: begin
        s_next.state = LD_OPT0;
      end
    endcase

    // Register writes (trim writes blocked while the loader owns the store)
    if (i_wr) begin
      case (i_addr)
        ADDR_TIMING_HIGH: s_next.tim_hi = i_wdata;
        ADDR_TIMING_LOW:  s_next.tim_lo = i_wdata;
        ADDR_TRIM_INDEX:  s_next.trim_idx = i_wdata;
        ADDR_TRIM_VALUE: begin
          if (!loading && (s_reg.trim_idx <= TRIM_INDEX_MAX)) begin
            trim_we    = 1'b1;
            trim_waddr = s_reg.trim_idx[4:0];
            trim_wdata = i_wdata;
          end
        end
        default: begin
        end
      endcase
    end

    // Register reads, answered in the next cycle
    s_next.rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        ADDR_TIMING_HIGH: s_next.rdata = s_reg.tim_hi;
        ADDR_TIMING_LOW:  s_next.rdata = s_reg.tim_lo;
        ADDR_TRIM_INDEX:  s_next.rdata = s_reg.trim_idx;
        ADDR_TRIM_VALUE:  s_next.rdata = (s_reg.trim_idx <= TRIM_INDEX_MAX) ? trim_rdata : 8'h00;
        ADDR_OPTION_ZERO: s_next.rdata = s_reg.opt0;
        ADDR_OPTION_ONE:  s_next.rdata = s_reg.opt1;
        ADDR_LOAD_STATUS: s_next.rdata = {7'h00, ~loading};
        default:          s_next.rdata = 8'h00;
      endcase
    end
  end

  // ============================================================
  // State register; option bytes only reload through reset
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_reg          <= '0;
      s_reg.state    <= LD_OPT0;
      s_reg.tim_hi   <= TIMING_RESET;
      s_reg.tim_lo   <= TIMING_RESET;
      s_reg.trim_idx <= TRIM_INDEX_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ============================================================
  // Outputs
  assign o_rdata              = s_reg.rdata;
  assign o_flash_timing_value = {s_reg.tim_hi, s_reg.tim_lo};
  assign o_option_one         = s_reg.opt1;
  // CPU held until both option bytes are in; a STOP trim reload keeps it released
  assign o_cpu_release        = (s_reg.state == LD_TRIM) || (s_reg.state == LD_DONE);

endmodule : flash_option_trim_config

// [hdl/option_cfg_pkg.sv]
package option_cfg_pkg;

  // ============================================================
  // Register map (byte offsets on the plain register port)
  localparam logic [11:0] ADDR_TRIM_INDEX   = 12'hFF6;
  localparam logic [11:0] ADDR_TRIM_VALUE   = 12'hFF7;
  localparam logic [11:0] ADDR_TIMING_HIGH  = 12'hFFA;
  localparam logic [11:0] ADDR_TIMING_LOW   = 12'hFFB;
  localparam logic [11:0] ADDR_OPTION_ZERO  = 12'hFF0;
  localparam logic [11:0] ADDR_OPTION_ONE   = 12'hFF1;
  localparam logic [11:0] ADDR_LOAD_STATUS  = 12'hFF2;

  // ============================================================
  // Reset values
  localparam logic [7:0]  TIMING_RESET      = 8'h00;
  localparam logic [7:0]  TRIM_INDEX_RESET  = 8'h00;

  // ============================================================
  // Option byte fields
  localparam int          OPT_WDT_ACTION    = 7;
  localparam int          OPT_WDT_AUTO      = 6;
  localparam int          OPT_OSC_HI        = 5;
  localparam int          OPT_OSC_LO        = 4;
  localparam int          OPT_BROWNOUT      = 3;
  localparam int          OPT_READ_PROT     = 2;
  localparam int          OPT_WRITE_LOCK    = 0;

  // ============================================================
  // Flash locations
  localparam logic [15:0] OPTION_ADDR_ZERO  = 16'h0000;
  localparam logic [15:0] OPTION_ADDR_ONE   = 16'h0001;
  localparam int          TRIM_COUNT        = 32;
  localparam logic [7:0]  TRIM_INDEX_MAX    = 8'h1F;

  // ============================================================
  // Loader states
  typedef enum logic [2:0] {
    LD_OPT0   = 3'b000,
    LD_OPT1   = 3'b001,
    LD_TRIM   = 3'b010,
    LD_DONE   = 3'b011
  } load_state_t;

endpackage : option_cfg_pkg

// [hdl/option_decode.sv]
`timescale 1ns/1ns
// Decodes the held first option byte into control levels
module option_decode (
  // Held option byte
  input  wire logic [7:0] i_option,
  // Decoded controls
  output logic            o_wdt_reset_on_timeout,
  output logic            o_wdt_auto_on,
  output logic [1:0]      o_osc_drive,
  output logic            o_osc_drive_reserved,
  output logic            o_brownout_always_on,
  output logic            o_read_protect,
  output logic            o_flash_write_lock
);
  import option_cfg_pkg::*;

  always_comb begin
    o_wdt_reset_on_timeout = i_option[OPT_WDT_ACTION];
    o_wdt_auto_on          = ~i_option[OPT_WDT_AUTO];
    o_osc_drive            = i_option[OPT_OSC_HI:OPT_OSC_LO];
    o_osc_drive_reserved   = (i_option[OPT_OSC_HI:OPT_OSC_LO] == 2'h0);
    o_brownout_always_on   = i_option[OPT_BROWNOUT];
    o_read_protect         = ~i_option[OPT_READ_PROT];
    o_flash_write_lock     = ~i_option[OPT_WRITE_LOCK];
  end

endmodule : option_decode

// [hdl/trim_store.sv]
`timescale 1ns/1ns
// Working copies of trim values, one entry per trim index
module trim_store #(
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  // Write port
  input  wire logic       i_we,
  input  wire logic [4:0] i_waddr,
  input  wire logic [7:0] i_wdata,
  // Read port
  input  wire logic [4:0] i_raddr,
  output logic [7:0]      o_rdata
);

  logic [7:0] mem_reg [DEPTH];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_entry
      // Contents are volatile: cleared at reset, then reloaded by the loader
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          mem_reg[g] <= 8'h00;
        end else if (i_we && (i_waddr == 5'(g))) begin
          mem_reg[g] <= i_wdata;
        end
      end
    end
  endgenerate

  assign o_rdata = mem_reg[i_raddr];

endmodule : trim_store

// [tb/flash_option_trim_config_sva.sv]
`timescale 1ns/1ns
module flash_option_trim_config_sva (
  // Clock and register port
  input wire logic        i_clk,
  input wire logic        i_arst_n,
  input wire logic [11:0] i_addr,
  input wire logic [7:0]  i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [7:0]  o_rdata,
  // Flash and options
  input wire logic [15:0] o_flash_addr,
  input wire logic        o_flash_info_sel,
  input wire logic        o_flash_rd,
  input wire logic [7:0]  i_flash_rdata,
  input wire logic        o_cpu_release,
  input wire logic [15:0] o_flash_timing_value,
  input wire logic        o_wdt_reset_on_timeout,
  input wire logic        o_wdt_auto_on,
  input wire logic [1:0]  o_osc_drive,
  input wire logic        o_osc_drive_reserved,
  input wire logic        o_brownout_always_on,
  input wire logic        o_read_protect,
  input wire logic        o_flash_write_lock
);
  import option_cfg_pkg::*;
  // ============================================================
  // Shadow of the trim index and of the fetched first option byte
  logic [7:0] idx_reg;
  logic [7:0] opt_reg;
  logic       rd0_reg;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      idx_reg <= 8'h00;
      opt_reg <= 8'h00;
      rd0_reg <= 1'b0;
    end else begin
      rd0_reg <= o_flash_rd && !o_flash_info_sel && o_flash_addr == OPTION_ADDR_ZERO;
      if (rd0_reg) opt_reg <= i_flash_rdata;
      if (i_wr && i_addr == ADDR_TRIM_INDEX) idx_reg <= i_wdata;
    end
  end
  // ============================================================
  // Properties
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  property p_timing_hi;
    i_wr && i_addr == ADDR_TIMING_HIGH |=> o_flash_timing_value[15:8] == $past(i_wdata);
  endproperty
  a_timing_hi: assert property (p_timing_hi) else $error("timing high byte wrong");
  property p_timing_lo;
    i_wr && i_addr == ADDR_TIMING_LOW |=> o_flash_timing_value[7:0] == $past(i_wdata);
  endproperty
  a_timing_lo: assert property (p_timing_lo) else $error("timing low byte wrong");
  property p_timing_hold;
    !i_wr |=> $stable(o_flash_timing_value);
  endproperty
  a_timing_hold: assert property (p_timing_hold) else $error("timing value moved");
  property p_rdata_idle;
    !i_rd |=> o_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
  property p_start;
    $rose(i_arst_n) |-> ##[0:2] (o_flash_rd && !o_flash_info_sel && o_flash_addr == OPTION_ADDR_ZERO);
  endproperty
  a_start: assert property (p_start) else $error("option fetch missing");
  property p_no_reload;
    o_cpu_release |-> !(o_flash_rd && !o_flash_info_sel);
  endproperty
  a_no_reload: assert property (p_no_reload) else $error("option read after release");
  property p_frozen;
    o_cpu_release |=> $stable({o_wdt_reset_on_timeout, o_wdt_auto_on, o_osc_drive,
                              o_brownout_always_on, o_read_protect, o_flash_write_lock});
  endproperty
  a_frozen: assert property (p_frozen) else $error("options changed");
  property p_decode;
    o_cpu_release |-> {o_wdt_reset_on_timeout, !o_wdt_auto_on, o_osc_drive, o_brownout_always_on,
                       !o_read_protect, !o_flash_write_lock} == {opt_reg[7:2], opt_reg[0]};
  endproperty
  a_decode: assert property (p_decode) else $error("option decode wrong");
  property p_osc_res;
    o_osc_drive_reserved == (o_osc_drive == 2'b00);
  endproperty
  a_osc_res: assert property (p_osc_res) else $error("reserved drive flag wrong");
  property p_trim_range;
    i_rd && i_addr == ADDR_TRIM_VALUE && idx_reg > TRIM_INDEX_MAX |=> o_rdata == 8'h00;
  endproperty
  a_trim_range: assert property (p_trim_range) else $error("out of range trim read");
endmodule : flash_option_trim_config_sva

bind flash_option_trim_config flash_option_trim_config_sva u_sva (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_flash_addr(o_flash_addr), .o_flash_info_sel(o_flash_info_sel),
  .o_flash_rd(o_flash_rd), .i_flash_rdata(i_flash_rdata), .o_cpu_release(o_cpu_release),
  .o_flash_timing_value(o_flash_timing_value), .o_wdt_reset_on_timeout(o_wdt_reset_on_timeout),
  .o_wdt_auto_on(o_wdt_auto_on), .o_osc_drive(o_osc_drive), .o_osc_drive_reserved(o_osc_drive_reserved),
  .o_brownout_always_on(o_brownout_always_on), .o_read_protect(o_read_protect),
  .o_flash_write_lock(o_flash_write_lock));

// [tb/flash_option_trim_config_tb.sv]
`timescale 1ns/1ns
module flash_option_trim_config_tb;
  import option_cfg_pkg::*;
  logic        i_clk, i_arst_n, i_wr, i_rd, i_stop_recover, info_sel, frd, rel;
  logic        wrt, wao, ors, bao, rpr, fwl;
  logic [1:0]  osc;
  logic [7:0]  i_wdata, i_flash_rdata, o_rdata, o1, opt0, fl0, opt1, v;
  logic [11:0] i_addr;
  logic [15:0] fa, tv, tim;
  logic [7:0]  info [32];
  logic [7:0]  trim [32];
  int          n_fail, total_checks, k, j;
  localparam logic [15:0] CLK_KHZ = 16'h2710;
  flash_option_trim_config #(.TRIM_DEPTH(32)) flash_option_trim_config_i (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_flash_addr(fa), .o_flash_info_sel(info_sel), .o_flash_rd(frd),
    .i_flash_rdata(i_flash_rdata), .i_stop_recover(i_stop_recover), .o_cpu_release(rel),
    .o_flash_timing_value(tv), .o_wdt_reset_on_timeout(wrt), .o_wdt_auto_on(wao), .o_osc_drive(osc),
    .o_osc_drive_reserved(ors), .o_brownout_always_on(bao), .o_read_protect(rpr),
    .o_flash_write_lock(fwl), .o_option_one(o1));
  // ============================================================
  // Clock, flash array and watchdog
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  always @(posedge i_clk) i_flash_rdata <= !frd ? ~i_flash_rdata : info_sel ? info[fa[4:0]] : fa[0] ? opt1 : fl0;
  initial begin
    repeat (30000) @(posedge i_clk);
    n_fail++;
    complete_run();
  end
  // ============================================================
  // Tasks
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd
  task do_reset;
    i_arst_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    i_arst_n <= 1'b1;
    #1 chk(rel, 1'b0);
    v = 8'h00;
    for (j = 0; j < 40 && !v[0]; j++) rd(ADDR_LOAD_STATUS, v);
    for (j = 0; j < 32; j++) trim[j] = info[j];
    tim = 16'h0000;
  endtask : do_reset
  task chk_all;
    chk({wrt, ~wao, osc, bao, ~rpr, 1'b1, ~fwl}, {opt0[7:2], 1'b1, opt0[0]});
    chk(ors, opt0[5:4] == 2'b00);
    chk(o1, opt1);
    chk(rel, 1'b1);
    chk(tv, tim);
    rd(ADDR_TIMING_HIGH, v);
    chk(v, tim[15:8]);
    for (j = 0; j < 32; j++) begin
      wr(ADDR_TRIM_INDEX, j[7:0]);
      rd(ADDR_TRIM_VALUE, v);
      chk(v, trim[j]);
    end
  endtask : chk_all
  task complete_run;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  // ============================================================
  // Main sequence
  initial begin
    {i_arst_n, i_wr, i_rd, i_stop_recover, i_addr, i_wdata, i_flash_rdata} = '0;
    {n_fail, total_checks} = '0;
    v = $urandom(59950);
    for (j = 0; j < 32; j++) info[j] = $urandom;
    opt1 = $urandom;
    for (k = 0; k < 4; k++) begin
      v = $urandom;
      fl0 = {v[7:6], k[1:0], v[3:2], 1'b1, v[0]};
      if (k == 3) fl0 = 8'hFF;
      if (k > 0) chk_all();
      do_reset();
      chk(v[0], 1);
      opt0 = fl0;
      chk_all();
      tim = (k == 0) ? CLK_KHZ : 16'($urandom);
      wr(ADDR_TIMING_HIGH, tim[15:8]);
      wr(ADDR_TIMING_LOW, tim[7:0]);
      for (j = k; j < 32; j += 5) begin
        trim[j] = $urandom;
        wr(ADDR_TRIM_INDEX, j[7:0]);
        wr(ADDR_TRIM_VALUE, trim[j]);
      end
      $display("test %0d done", k);
    end
    wr(ADDR_TRIM_INDEX, 8'h20);
    wr(ADDR_TRIM_VALUE, 8'hA5);
    rd(ADDR_TRIM_VALUE, v);
    chk(v, 8'h00);
    rd(12'h800, v);
    chk(v, 8'h00);
    @(posedge i_clk);
    i_stop_recover <= 1'b1;
    @(posedge i_clk);
    i_stop_recover <= 1'b0;
    #1 chk(rel, 1'b1);
    rd(ADDR_LOAD_STATUS, v);
    chk(v, 8'h00);
    repeat (80) @(posedge i_clk);
    for (j = 0; j < 32; j++) trim[j] = info[j];
    chk_all();
    $display("test stop recovery done");
    complete_run();
  end
endmodule : flash_option_trim_config_tb
